/* File: src/muac_consts.svh */
// Constants of the user command channel: register offsets, field positions, reset values, timing.
// Assumes a 250 MHz core clock and a 32-bit register port with byte addresses.
`ifndef MUAC_CONSTS_SVH
`define MUAC_CONSTS_SVH

// Register byte offsets
`define MUAC_OFS_ACCESS0     8'h00
`define MUAC_OFS_PHYSEL0     8'h04
`define MUAC_OFS_RAW         8'h08
`define MUAC_OFS_MASKED      8'h0C
`define MUAC_OFS_MASK_SET    8'h10
`define MUAC_OFS_MASK_CLEAR  8'h14
`define MUAC_OFS_CTRL        8'h18
`define MUAC_OFS_LINK_EVENT  8'h1C

// Command channel fields
`define MUAC_START_BIT       31
`define MUAC_DIR_BIT         30
`define MUAC_ACK_BIT         29
`define MUAC_REG_HI          25
`define MUAC_REG_LO          21
`define MUAC_PHY_HI          20
`define MUAC_PHY_LO          16
`define MUAC_DATA_HI         15

// Monitor select fields
`define MUAC_LINK_SEL_BIT    7
`define MUAC_LINK_IRQ_EN_BIT 6
`define MUAC_MON_PHY_HI      4

// Reset values
`define MUAC_RST_ACCESS      32'h0000_0000
`define MUAC_RST_CHAN        2'h0

// Frame layout, counted in bits from the first preamble bit
`define MUAC_FRAME_BITS      7'h40
`define MUAC_TA_FIRST        7'h2E
`define MUAC_TA_SECOND       7'h2F
`define MUAC_DATA_FIRST      7'h30

// Management clock: least half period in ns, core period in ns
`define MUAC_MDC_HALF_NS     200
`define MUAC_CORE_NS         4
`define MUAC_MDC_HALF_CYC    ((`MUAC_MDC_HALF_NS + `MUAC_CORE_NS - 1) / `MUAC_CORE_NS)

`endif

/* File: src/muac_pkg.sv */
// Types of the user command channel: serial state and the module's whole state.
// Assumes muac_consts.svh is in the include path.
package muac_pkg;

   typedef enum logic [2:0] {
      MUAC_IDLE  = 3'b001,
      MUAC_SHIFT = 3'b010,
      MUAC_DONE  = 3'b100
   } muac_state_t;

   typedef struct packed {
      muac_state_t state;
      logic        start;       // Busy while the serial access runs
      logic        dir_write;
      logic        ack;
      logic [4:0]  reg_num;
      logic [4:0]  phy_num;
      logic [15:0] data;
      logic        link_sel;
      logic        link_irq_en;
      logic [4:0]  mon_phy;
      logic [1:0]  raw;
      logic [1:0]  mask;
      logic        enable;
      logic        link_event;
      logic [7:0]  div_cnt;
      logic        mdc;
      logic        mdio_out;
      logic        mdio_oe;
      logic [63:0] shreg;
      logic [6:0]  bit_cnt;
      logic        mdio_s1;
      logic        mdio_s2;
      logic        link_s1;
      logic        link_s2;
      logic        link_prev;
      logic [31:0] rdata;
      logic        irq;
   } muac_regs_t;

endpackage

/* File: src/muac_top.sv */
// User command channel of a management serial controller: registers, frame engine, interrupt.
// Assumes a single 250 MHz clock, an external PHY on the serial pins and software on the register port.
`timescale 1ns/1ns
`include "muac_consts.svh"

// Register map, byte offsets on the register port
//   0x00 command channel: start, direction, acknowledge, register, PHY, data
//   0x04 monitor select: link source, link interrupt enable, monitored PHY
//   0x08 raw completion events, write one to clear
//   0x0C masked completion events, write one clears the raw event
//   0x10 mask set, write one enables, reads back the mask
//   0x14 mask clear, write one disables, reads back the mask
//   0x18 control, bit 0 enables the frame engine
//   0x1C link change event, write one to clear
//   Other offsets read zero and ignore writes

// Register port timing
//   A write is one cycle with the write strobe and acts at that edge.
//   A read is one cycle with the read strobe; its data stand in the next
//   cycle only and read zero otherwise. The port never waits.

// Frame on the serial line, one bit per management clock period
//   bits  0-31 preamble, all ones
//   bits 32-33 start pattern 01
//   bits 34-35 opcode, 10 read, 01 write
//   bits 36-40 target PHY number, most significant bit first
//   bits 41-45 target register number
//   bits 46-47 turnaround: 10 driven on a write, released on a read
//   bits 48-63 data, most significant bit first
// The engine drives each bit after a falling edge of the clock
// and samples the line in the last core cycle before the rising edge.
// The pin synchroniser delays the line by two core cycles, so the
// low phase of the clock must last at least three core cycles.

// Limitations for the user
//   Only channel 0 is built; raw bit 1 never sets, mask bit 1 is only stored.
//   The monitored PHY number is stored only; link events follow the link pin.
//   A link event needs the enable set at the time of the change.
//   The acknowledge bit is cleared as a read frame starts, kept on a write.
//   Clearing the engine enable does not stop a frame in flight.
//   The clock stands low between frames and never runs free.
//   Interrupt output is a level; it falls at the same edge as the last clear.
//   A read in the same cycle as a write returns the old value.

module muac_top
   import muac_pkg::*;
#(
   parameter logic [7:0] MDC_HALF = 8'(`MUAC_MDC_HALF_CYC)
) (
   // Clock and reset
   input  wire logic        i_core_clk,
   input  wire logic        i_arst_n,
   // Register port
   input  wire logic [7:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [31:0] o_rdata,
   // Interrupt
   output logic             o_irq,
   // Serial pins
   output logic             o_mdc,
   input  wire logic        i_mdio,
   output logic             o_mdio_out,
   output logic             o_mdio_oe,
   // Link status pin
   input  wire logic        i_link_up
);

   // Whole state and its next value
   muac_regs_t r;
   muac_regs_t next_r;

   logic       wr_access;
   logic       wr_physel;
   logic       wr_raw;
   logic       wr_mset;
   logic       wr_mclr;
   logic       wr_ctrl;
   logic       wr_link;
   logic       mdc_rise;
   logic       mdc_fall;
   logic       done_evt;
   logic       link_evt;
   logic [1:0] masked;
   logic [6:0] cur_bit;
   logic       drive_now;
   logic       sample_now;
   logic [31:0] word_access;
   logic [31:0] word_physel;

   // Register write decode; the masked view shares the clear of the raw events
   // Unmapped offsets match nothing, so such writes fall away
   assign wr_access = i_wr && (i_addr == `MUAC_OFS_ACCESS0);
   assign wr_physel = i_wr && (i_addr == `MUAC_OFS_PHYSEL0);
   assign wr_raw    = i_wr && (i_addr == `MUAC_OFS_RAW || i_addr == `MUAC_OFS_MASKED);
   assign wr_mset   = i_wr && (i_addr == `MUAC_OFS_MASK_SET);
   assign wr_mclr   = i_wr && (i_addr == `MUAC_OFS_MASK_CLEAR);
   assign wr_ctrl   = i_wr && (i_addr == `MUAC_OFS_CTRL);
   assign wr_link   = i_wr && (i_addr == `MUAC_OFS_LINK_EVENT);

   // Clock edges and events seen by the frame engine
   assign mdc_rise = (r.div_cnt == MDC_HALF - 8'h01) && !r.mdc && (r.state == MUAC_SHIFT);
   assign mdc_fall = (r.div_cnt == MDC_HALF - 8'h01) && r.mdc;
   assign done_evt = (r.state == MUAC_DONE);
   assign link_evt = r.link_irq_en && (r.link_s2 != r.link_prev);
   assign masked   = r.raw & r.mask;
   assign cur_bit  = r.bit_cnt - 7'h01;

   // Drive strobe: every falling edge, and the first bit as the frame opens
   assign drive_now  = mdc_fall || (r.bit_cnt == 7'h00 && !r.mdc && r.div_cnt == 8'h00);
   assign sample_now = mdc_rise && !r.dir_write;

   // Read words of the wider registers, reserved bits zero
   assign word_access = {r.start, r.dir_write, r.ack, 3'h0, r.reg_num, r.phy_num, r.data};
   assign word_physel = {24'h00_0000, r.link_sel, r.link_irq_en, 1'b0, r.mon_phy};

   // Next-state logic of the whole block
   // Every section starts from the registered state, so later sections
   // override earlier ones only where stated
   always_comb begin
      next_r = r;

      // Pin synchronisers; only the second stage feeds logic
      next_r.mdio_s1   = i_mdio;
      next_r.mdio_s2   = r.mdio_s1;
      next_r.link_s1   = i_link_up;
      next_r.link_s2   = r.link_s1;
      next_r.link_prev = r.link_s2;

      // Management clock divider, runs only during a frame
      // A high phase in progress is always finished before the clock stops
      if (r.state == MUAC_SHIFT || r.mdc) begin
         if (r.div_cnt == MDC_HALF - 8'h01) begin
            next_r.div_cnt = 8'h00;
            next_r.mdc     = !r.mdc;
         end else begin
            next_r.div_cnt = r.div_cnt + 8'h01;
         end
      end else begin
         next_r.div_cnt = 8'h00;
      end

      // Command channel write, blocked while busy
      // Fields are taken only with no access pending, so a frame in flight
      // keeps its address, direction and data; start is stored only while
      // the engine is enabled, and a written zero leaves it low
      if (wr_access && !r.start) begin
         next_r.dir_write = i_wdata[`MUAC_DIR_BIT];
         next_r.ack       = i_wdata[`MUAC_ACK_BIT];
         next_r.reg_num   = i_wdata[`MUAC_REG_HI:`MUAC_REG_LO];
         next_r.phy_num   = i_wdata[`MUAC_PHY_HI:`MUAC_PHY_LO];
         next_r.data      = i_wdata[`MUAC_DATA_HI:0];
         next_r.start     = i_wdata[`MUAC_START_BIT] && r.enable;
      end

      // Monitor select; link source select stays at its only legal value
      if (wr_physel) begin
         next_r.link_irq_en = i_wdata[`MUAC_LINK_IRQ_EN_BIT];
         next_r.mon_phy     = i_wdata[`MUAC_MON_PHY_HI:0];
      end
      next_r.link_sel = 1'b0;

      // Control register
      if (wr_ctrl) begin
         next_r.enable = i_wdata[0];
      end

      // Mask set and clear, zeros ignored
      // One strobe per cycle, so set and clear never meet
      if (wr_mset) begin
         next_r.mask = r.mask | i_wdata[1:0];
      end
      if (wr_mclr) begin
         next_r.mask = r.mask & ~i_wdata[1:0];
      end

      // Frame engine
      //   Idle: waits for start, loads the whole frame into the shifter
      //   Shift: drives bits on falling edges, samples reads on rising edges
      //   Done: one cycle that clears busy and raises the completion event
      unique case (r.state)
         MUAC_IDLE: begin
            if (r.start) begin
               next_r.shreg   = {32'hFFFF_FFFF,                            // Preamble
                                 2'b01,                                    // Start pattern
                                 r.dir_write ? 2'b01 : 2'b10,              // Opcode
                                 r.phy_num,
                                 r.reg_num,
                                 2'b10,                                    // Turnaround
                                 r.data};
               next_r.bit_cnt = 7'h00;
               next_r.state   = MUAC_SHIFT;
               if (!r.dir_write) begin
                  next_r.ack = 1'b0;
               end
            end
         end
         MUAC_SHIFT: begin
            // Drive on the falling edge
            if (drive_now) begin
               // The falling edge after the last bit releases the line
               if (r.bit_cnt == `MUAC_FRAME_BITS) begin
                  next_r.mdio_oe = 1'b0;
                  next_r.state   = MUAC_DONE;
               end else begin
                  next_r.mdio_out = r.shreg[63];
                  next_r.mdio_oe  = r.dir_write || (r.bit_cnt < `MUAC_TA_FIRST);
                  next_r.shreg    = {r.shreg[62:0], 1'b0};
                  next_r.bit_cnt  = r.bit_cnt + 7'h01;
               end
            end
            // Sample on the rising edge during a read
            if (sample_now) begin
               // Second turnaround bit low means the PHY answered
               if (cur_bit == `MUAC_TA_SECOND) begin
                  next_r.ack = !r.mdio_s2;
               end
               // Data bits shift in most significant first
               if (cur_bit >= `MUAC_DATA_FIRST) begin
                  next_r.data = {r.data[14:0], r.mdio_s2};
               end
            end
         end
         MUAC_DONE: begin
            // Busy falls in the same cycle as the event rises
            next_r.start  = 1'b0;
            next_r.state  = MUAC_IDLE;
         end
      endcase

      // Sticky events; hardware set wins over software clear
      // A completion and a clear in one cycle leave the event set,
      // so software never loses one
      if (wr_raw) begin
         next_r.raw = r.raw & ~i_wdata[1:0];
      end
      if (done_evt) begin
         next_r.raw[0] = 1'b1;
      end
      if (wr_link && i_wdata[0]) begin
         next_r.link_event = 1'b0;
      end
      if (link_evt) begin
         next_r.link_event = 1'b1;
      end

      // Read data, one cycle after the strobe
      // Zero in every other cycle, so a stale word is never seen
      next_r.rdata = 32'h0000_0000;
      if (i_rd) begin
         unique case (i_addr)
            `MUAC_OFS_ACCESS0:    next_r.rdata = word_access;
            `MUAC_OFS_PHYSEL0:    next_r.rdata = word_physel;
            `MUAC_OFS_RAW:        next_r.rdata = {30'h0, r.raw};
            `MUAC_OFS_MASKED:     next_r.rdata = {30'h0, masked};
            `MUAC_OFS_MASK_SET:   next_r.rdata = {30'h0, r.mask};
            `MUAC_OFS_MASK_CLEAR: next_r.rdata = {30'h0, r.mask};
            `MUAC_OFS_CTRL:       next_r.rdata = {31'h0, r.enable};
            `MUAC_OFS_LINK_EVENT: next_r.rdata = {31'h0, r.link_event};
            default:              next_r.rdata = 32'h0000_0000;
         endcase
      end

      // Level interrupt from the next event state
      // Taken from the next value so the output flop rises with the event
      next_r.irq = |(next_r.raw & next_r.mask) || next_r.link_event;
   end

   // State register
   // Reset gives every field a constant: engine idle, clock low, line released
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         r <= '{
            state:       MUAC_IDLE,
            start:       1'b0,
            dir_write:   1'b0,
            ack:         1'b0,
            reg_num:     5'h00,
            phy_num:     5'h00,
            data:        16'h0000,
            link_sel:    1'b0,
            link_irq_en: 1'b0,
            mon_phy:     5'h00,
            raw:         `MUAC_RST_CHAN,
            mask:        `MUAC_RST_CHAN,
            enable:      1'b0,
            link_event:  1'b0,
            div_cnt:     8'h00,
            mdc:         1'b0,
            mdio_out:    1'b0,
            mdio_oe:     1'b0,
            shreg:       64'h0000_0000_0000_0000,
            bit_cnt:     7'h00,
            mdio_s1:     1'b0,
            mdio_s2:     1'b0,
            link_s1:     1'b0,
            link_s2:     1'b0,
            link_prev:   1'b0,
            rdata:       32'h0000_0000,
            irq:         1'b0
         };
      end else begin
         r <= next_r;
      end
   end

   // Outputs straight from flip-flops
   assign o_rdata    = r.rdata;
   assign o_irq      = r.irq;
   assign o_mdc      = r.mdc;
   assign o_mdio_out = r.mdio_out;
   assign o_mdio_oe  = r.mdio_oe;

endmodule

/* File: verif/muac_chk.sv */
// Assertions on the register port and serial clock of the user command channel.
// Assumes it is bound into muac_top and sees only that module's ports.
`timescale 1ns/1ns
module muac_chk #(
   parameter logic [7:0] MDC_HALF = 8'h32
) (
   input wire logic        i_core_clk,
   input wire logic        i_arst_n,
   input wire logic [7:0]  i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [31:0] o_rdata,
   input wire logic        o_mdc
);
   logic [7:0] hi_cnt;

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_arst_n);

   // Length of the high phase of the management clock
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n)
         hi_cnt <= 8'h00;
      else
         hi_cnt <= o_mdc ? hi_cnt + 8'h01 : 8'h00;
   end

   // Fixed and reserved bits read back as zero
   a_link_source_select_zero: assert property (i_rd && i_addr == 8'h04 |=> !o_rdata[7])
      else $error("link source select not zero");
   a_physel_rsvd: assert property (i_rd && i_addr == 8'h04 |=> o_rdata[31:8] == 24'h0 && !o_rdata[5])
      else $error("monitor select reserved bits set");
   a_access_rsvd: assert property (i_rd && i_addr == 8'h00 |=> o_rdata[28:26] == 3'h0)
      else $error("command reserved bits set");
   a_raw_rsvd: assert property (i_rd && i_addr == 8'h08 |=> o_rdata[31:2] == 30'h0)
      else $error("raw event reserved bits set");
   // Mask writes take effect for the next read
   a_clear_mask: assert property (i_wr && i_addr == 8'h14 && i_wdata[0] ##1 i_rd && i_addr == 8'h10 |=> !o_rdata[0])
      else $error("mask bit survived clear");
   a_set_mask: assert property (i_wr && i_addr == 8'h10 && i_wdata[0] ##1 i_rd && i_addr == 8'h10 |=> o_rdata[0])
      else $error("mask bit not set");
   a_masked_gate: assert property (i_wr && i_addr == 8'h14 && i_wdata[0] ##1 i_rd && i_addr == 8'h0C |=> !o_rdata[0])
      else $error("masked event shown while masked");
   // Every high phase of the serial clock lasts the set count
   a_mdc_half: assert property ($fell(o_mdc) |-> hi_cnt == MDC_HALF)
      else $error("serial clock high phase wrong");
endmodule

bind muac_top muac_chk #(.MDC_HALF(MDC_HALF)) u_chk (
   .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_mdc(o_mdc)
);

/* File: verif/muac_phy_model.sv */
// Behavioural PHY on the management serial pins: records frames, answers reads.
// Assumes the bench resolves the shared line with a pull-up.
`timescale 1ns/1ns
module muac_phy_model (
   input  wire logic        i_mdc,
   input  wire logic        i_line,
   input  wire logic        i_ack_en,
   input  wire logic [15:0] i_rd_value,
   output logic             o_oe,
   output logic             o_out,
   output logic [31:0]      o_frame
);
   int          cnt = 0;
   int          ones = 0;
   logic        rd = 1'b0;
   logic [31:0] sh = 32'h0;

   initial {o_oe, o_out, o_frame} = 34'h0;

   // Samples each bit on the rising edge and finds the start after the preamble
   always @(posedge i_mdc) begin
      sh = {sh[30:0], i_line};
      if (cnt != 0)
         cnt = cnt + 1;
      else if (ones >= 32 && !i_line)
         cnt = 32;
      ones = i_line ? ones + 1 : 0;
      if (cnt == 35)
         rd = (sh[1:0] == 2'b10);
      if (cnt == 63) begin
         o_frame = sh;
         cnt = 0;
      end
   end

   // Drives acknowledge and data after the falling edge, held through the high phase
   always @(negedge i_mdc) begin
      o_oe = rd && i_ack_en && cnt >= 46;
      o_out = (cnt >= 47) ? i_rd_value[62 - cnt] : 1'b0;
   end
endmodule

/* File: verif/tb.sv */
// Bench of the user command channel: register tasks issue commands, a PHY model answers.
// Assumes the design and the PHY model are compiled first.
`timescale 1ns/1ns
module tb;
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        link_up = 1'b0;
   logic        ack_en = 1'b1;
   logic [31:0] rdata, got, frame;
   logic        irq, mdc, mdio_out, mdio_oe, phy_oe, phy_out;
   int          mismatches = 0;
   int          tests_run = 0;
   int          cyc = 0;
   wire         line = mdio_oe ? mdio_out : (phy_oe ? phy_out : 1'b1);

   muac_top #(.MDC_HALF(8'h04)) uut (
      .i_core_clk(clk), .i_arst_n(arst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
      .o_rdata(rdata), .o_irq(irq), .o_mdc(mdc), .i_mdio(line), .o_mdio_out(mdio_out),
      .o_mdio_oe(mdio_oe), .i_link_up(link_up));
   muac_phy_model u_phy (.i_mdc(mdc), .i_line(line), .i_ack_en(ack_en), .i_rd_value(16'h3C96),
      .o_oe(phy_oe), .o_out(phy_out), .o_frame(frame));

   always #2 clk = ~clk;

   // Cuts a hung run short
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         mismatches++;
         conclude();
      end
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic put(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      {wr, rd, addr, wdata} <= {2'b10, a, d};
   endtask

   task automatic get(input logic [7:0] a, output logic [31:0] g);
      @(posedge clk);
      {wr, rd, addr} <= {2'b01, a};
      @(posedge clk);
      {wr, rd} <= 2'b00;
      #1 g = rdata;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      get(a, got);
      chk(got, e);
   endtask

   task automatic idle(input int n);
      @(posedge clk);
      {wr, rd} <= 2'b00;
      repeat (n) @(posedge clk);
   endtask

   task automatic wait_done;
      got = 32'h8000_0000;
      for (int n = 0; n < 500 && got[31] !== 1'b0; n++)
         get(8'h00, got);
      chk({31'h0, got[31]}, 32'h0);
   endtask

   task automatic conclude;
      $display("Checks %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Register commands, serial frames and interrupts in turn
   initial begin
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      for (int a = 0; a <= 32; a += 4)
         rchk(8'(a), 32'h0);
      put(8'h00, 32'h8145_1234);
      rchk(8'h00, 32'h0145_1234);
      put(8'h18, 32'h1);
      put(8'h10, 32'h1);
      rchk(8'h10, 32'h1);
      put(8'h14, 32'h0);
      rchk(8'h10, 32'h1);
      put(8'h00, 32'hC27B_A55A);
      put(8'h00, 32'h0);
      rchk(8'h00, 32'hC27B_A55A);
      wait_done();
      rchk(8'h00, 32'h427B_A55A);
      chk(frame, {4'h5, 5'h1B, 5'h13, 2'h2, 16'hA55A});
      chk({31'h0, irq}, 32'h1);
      rchk(8'h08, 32'h1);
      put(8'h14, 32'h1);
      rchk(8'h10, 32'h0);
      put(8'h14, 32'h1);
      rchk(8'h0C, 32'h0);
      chk({31'h0, irq}, 32'h0);
      put(8'h08, 32'h1);
      rchk(8'h08, 32'h0);
      put(8'h00, 32'h80F1_0000);
      wait_done();
      rchk(8'h00, 32'h20F1_3C96);
      chk(frame, {4'h6, 5'h11, 5'h07, 2'h2, 16'h3C96});
      ack_en <= 1'b0;
      put(8'h00, 32'h80F1_0000);
      wait_done();
      rchk(8'h00, 32'h00F1_FFFF);
      chk(frame, {4'h6, 5'h11, 5'h07, 2'h3, 16'hFFFF});
      put(8'h04, 32'hFFFF_FFFF);
      rchk(8'h04, 32'h0000_005F);
      link_up <= 1'b1;
      idle(8);
      chk({31'h0, irq}, 32'h1);
      put(8'h1C, 32'h1);
      put(8'h04, 32'h1F);
      idle(1);
      link_up <= 1'b0;
      idle(8);
      chk({31'h0, irq}, 32'h0);
      rchk(8'h1C, 32'h0);
      conclude();
   end
endmodule
